// File: port_power_source_cfg_defs.vh
/*
 Offsets, field positions, encodings and reset values for the port power source
 configuration bank. Assumes inclusion by bare name from the design files.
*/
`ifndef PORT_POWER_SOURCE_CFG_DEFS_VH
`define PORT_POWER_SOURCE_CFG_DEFS_VH

`define PORT2_CFG_OFFSET 16'h3c04
`define PORT3_CFG_OFFSET 16'h3c08
`define CFG_SHARED_PINS_BIT 7
`define CFG_RSVD_BIT 6
`define CFG_PERM_DISABLE_BIT 5
`define CFG_FIXED_DEV_BIT 4
`define CFG_SRC_MSB 3
`define CFG_SRC_LSB 0
`define SRC_OFF 4'h0
`define SRC_HS_HUB 4'h1
`define SRC_SS_HUB 4'h2
`define SRC_EITHER_HUB 4'h3
`define SRC_GPIO 4'h4
`define CFG_RESET_VAL 8'h00
`define CFG_WRITE_MASK 8'hbf

`endif

// File: port_power_select.v
/*
 Per-port power source selector: decodes one 4-bit source field.
 Assumes all inputs are synchronous to mclk_i.
*/
`timescale 1ns/100ps
`include "port_power_source_cfg_defs.vh"

module port_power_select (
  input wire [3:0] src_sel_i,
  input wire hs_power_i,
  input wire ss_power_i,
  input wire gpio_power_i,
  output reg power_on_o
);
  always @* begin
    case (src_sel_i)
      `SRC_OFF: power_on_o = 1'b0;
      `SRC_HS_HUB: power_on_o = hs_power_i;
      `SRC_SS_HUB: power_on_o = ss_power_i;
      `SRC_EITHER_HUB: power_on_o = hs_power_i | ss_power_i;
      `SRC_GPIO: power_on_o = gpio_power_i;
      default: power_on_o = 1'b0;
    endcase
  end
endmodule // port_power_select

// File: port_power_source_config.v
/*
 Port 2 and port 3 power source configuration registers on an APB slave, with
 per-port power switch enables. Assumes APB master on mclk_i; hub power state and
 GPIO inputs arrive from other clock domains and are synchronised here.
*/
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
`include "port_power_source_cfg_defs.vh"

// Contract
// - Bit 7 selects shared or separate pins
// - Bit 5 marks port permanently disabled
// - Bit 4 marks fixed attached device
// - Source 0000b keeps power always off
// - Source 0001b follows USB2 power state
// - Source 0010b follows USB3 power state
// - Source 0011b ORs USB2 and USB3
// - Source 0100b follows designated GPIO
// - Port 3 uses same source encoding
module port_power_source_config #(
  parameter NUM_PORTS = 2
) (
  input wire mclk_i,
  input wire srst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [15:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire [NUM_PORTS-1:0] hs_power_i,
  input wire [NUM_PORTS-1:0] ss_power_i,
  input wire [NUM_PORTS-1:0] gpio_power_i,
  output reg [NUM_PORTS-1:0] port_power_en_o,
  output reg [NUM_PORTS-1:0] shared_pins_o,
  output reg [NUM_PORTS-1:0] perm_disable_o,
  output reg [NUM_PORTS-1:0] fixed_attached_device_o
);
  // Configuration registers
  reg [7:0] port2_power_source_cfg_r;
  reg [7:0] port3_power_source_cfg_r;
  reg [7:0] port2_power_source_cfg_nxt;
  reg [7:0] port3_power_source_cfg_nxt;

  // Bus answer next values
  reg pready_nxt;
  reg pslverr_nxt;
  reg [31:0] prdata_nxt;

  // Synchroniser stages, one pair per input group
  reg [NUM_PORTS-1:0] hs_meta_r;
  reg [NUM_PORTS-1:0] hs_sync_r;
  reg [NUM_PORTS-1:0] ss_meta_r;
  reg [NUM_PORTS-1:0] ss_sync_r;
  reg [NUM_PORTS-1:0] gpio_meta_r;
  reg [NUM_PORTS-1:0] gpio_sync_r;

  // Per-port decoded values
  wire [NUM_PORTS-1:0] power_on;
  wire [NUM_PORTS-1:0] shared_pins_nxt;
  wire [NUM_PORTS-1:0] perm_disable_nxt;
  wire [NUM_PORTS-1:0] fixed_attached_device_nxt;
  wire [15:0] cfg_flat;

  // Bus decode
  wire setup;
  wire access;
  wire sel_p2;
  wire sel_p3;
  wire hit;
  wire wr_commit;
  wire wr_p2;
  wire wr_p3;
  wire rd_setup;
  wire [7:0] wdata_masked;

  assign setup = psel_i & ~penable_i;
  assign access = psel_i & penable_i;
  assign sel_p2 = (paddr_i == `PORT2_CFG_OFFSET);
  assign sel_p3 = (paddr_i == `PORT3_CFG_OFFSET);
  assign hit = sel_p2 | sel_p3;

  // Writes land only on the edge that completes the access phase
  assign wr_commit = access & pready_o & pwrite_i & pstrb_i[0];
  assign wr_p2 = wr_commit & sel_p2;
  assign wr_p3 = wr_commit & sel_p3;
  assign rd_setup = setup & ~pwrite_i;
  assign wdata_masked = pwdata_i[7:0] & `CFG_WRITE_MASK;

  // Port 2 in the low byte, port 3 in the high byte
  assign cfg_flat = {port3_power_source_cfg_r, port2_power_source_cfg_r};

  // Two-stage synchroniser for hub and GPIO power states
  always @(posedge mclk_i) begin
    if (srst_i) begin
      hs_meta_r <= {NUM_PORTS{1'b0}};
      ss_meta_r <= {NUM_PORTS{1'b0}};
      gpio_meta_r <= {NUM_PORTS{1'b0}};
    end else begin
      hs_meta_r <= hs_power_i;
      ss_meta_r <= ss_power_i;
      gpio_meta_r <= gpio_power_i;
    end
  end

  always @(posedge mclk_i) begin
    if (srst_i) begin
      hs_sync_r <= {NUM_PORTS{1'b0}};
      ss_sync_r <= {NUM_PORTS{1'b0}};
      gpio_sync_r <= {NUM_PORTS{1'b0}};
    end else begin
      hs_sync_r <= hs_meta_r;
      ss_sync_r <= ss_meta_r;
      gpio_sync_r <= gpio_meta_r;
    end
  end

  // Register next values
  always @* begin
    port2_power_source_cfg_nxt = port2_power_source_cfg_r;
    port3_power_source_cfg_nxt = port3_power_source_cfg_r;
    if (wr_p2) begin
      port2_power_source_cfg_nxt = wdata_masked;
    end
    if (wr_p3) begin
      port3_power_source_cfg_nxt = wdata_masked;
    end
  end

  // Answer next values: ready one cycle after setup
  always @* begin
    pready_nxt = setup;
    pslverr_nxt = setup & ~hit;
    prdata_nxt = prdata_o;
    if (setup) begin
      prdata_nxt = 32'h0000_0000;
    end
    if (rd_setup & sel_p2) begin
      prdata_nxt = {24'h00_0000, port2_power_source_cfg_r & `CFG_WRITE_MASK};
    end else if (rd_setup & sel_p3) begin
      prdata_nxt = {24'h00_0000, port3_power_source_cfg_r & `CFG_WRITE_MASK};
    end
  end

  // Configuration storage
  always @(posedge mclk_i) begin
    if (srst_i) begin
      port2_power_source_cfg_r <= `CFG_RESET_VAL;
      port3_power_source_cfg_r <= `CFG_RESET_VAL;
    end else begin
      port2_power_source_cfg_r <= port2_power_source_cfg_nxt;
      port3_power_source_cfg_r <= port3_power_source_cfg_nxt;
    end
  end

  // Bus answer flops
  always @(posedge mclk_i) begin
    if (srst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= pready_nxt;
      pslverr_o <= pslverr_nxt;
      prdata_o <= prdata_nxt;
    end
  end

  // Per-port source decode and flag taps
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g = g + 1) begin : g_port
      port_power_select port_power_select_inst (
        .src_sel_i(cfg_flat[8*g+`CFG_SRC_MSB:8*g+`CFG_SRC_LSB]),
        .hs_power_i(hs_sync_r[g]),
        .ss_power_i(ss_sync_r[g]),
        .gpio_power_i(gpio_sync_r[g]),
        .power_on_o(power_on[g])
      );
      assign shared_pins_nxt[g] = cfg_flat[8*g+`CFG_SHARED_PINS_BIT];
      assign perm_disable_nxt[g] = cfg_flat[8*g+`CFG_PERM_DISABLE_BIT];
      assign fixed_attached_device_nxt[g] = cfg_flat[8*g+`CFG_FIXED_DEV_BIT];
    end
  endgenerate

  // Output flops
  always @(posedge mclk_i) begin
    if (srst_i) begin
      port_power_en_o <= {NUM_PORTS{1'b0}};
      shared_pins_o <= {NUM_PORTS{1'b0}};
      perm_disable_o <= {NUM_PORTS{1'b0}};
      fixed_attached_device_o <= {NUM_PORTS{1'b0}};
    end else begin
      port_power_en_o <= power_on;
      shared_pins_o <= shared_pins_nxt;
      perm_disable_o <= perm_disable_nxt;
      fixed_attached_device_o <= fixed_attached_device_nxt;
    end
  end
endmodule // port_power_source_config

// File: port_power_source_config_properties.sv
/* Port-level checks for the config bank. Assumes binding to its top module. */
`timescale 1ns/100ps
module port_power_source_config_properties #(parameter NUM_PORTS = 2) (
  input wire mclk_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o,
  input wire [15:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire [NUM_PORTS-1:0] hs_power_i, ss_power_i, gpio_power_i, port_power_en_o,
  input wire [NUM_PORTS-1:0] shared_pins_o, perm_disable_o, fixed_attached_device_o);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  wire setup = psel_i && !penable_i;
  ready_after_setup_a: assert property (setup |=> pready_o) else $error("late ready");
  unmapped_err_a: assert property (setup && paddr_i != 16'h3c04 && paddr_i != 16'h3c08 |=> pslverr_o) else $error("no err");
  read_zero_a: assert property (pready_o |-> prdata_o[31:8] == 0 && !prdata_o[6]) else $error("bad read");
  port2_src_a: assert property (port_power_en_o[0] |-> $past(hs_power_i[0] | ss_power_i[0] | gpio_power_i[0], 3))
    else $error("power on");
  port3_src_a: assert property (port_power_en_o[1] |-> $past(hs_power_i[1] | ss_power_i[1] | gpio_power_i[1], 3))
    else $error("power on");
  shared_write_a: assert property ($changed(shared_pins_o) |-> $past(setup && pwrite_i, 3)) else $error("flag");
  perm_write_a: assert property ($changed(perm_disable_o) |-> $past(setup && pwrite_i, 3)) else $error("flag");
  fixed_write_a: assert property ($changed(fixed_attached_device_o) |-> $past(setup && pwrite_i, 3)) else $error("flag");
  cover property (pslverr_o);
  cover property (port_power_en_o[1]);
  cover property (perm_disable_o[1]);
endmodule // port_power_source_config_properties
bind port_power_source_config port_power_source_config_properties #(.NUM_PORTS(NUM_PORTS)) props_inst (.*);

// File: tb_port_power_source_config.sv
/* Bench for the config bank over APB. Assumes the design and its checker. */
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; $display("unexpected %0t %h", $time, a); end end
module tb_port_power_source_config;
  logic mclk_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o, e, x;
  logic [15:0] paddr_i = 16'h0000;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, r;
  logic [3:0] pstrb_i = 4'hf;
  logic [1:0] hs_power_i = 0, ss_power_i = 0, gpio_power_i = 0, port_power_en_o, shared_pins_o, perm_disable_o;
  logic [1:0] fixed_attached_device_o;
  int fail_count = 0, checked = 0, p, c, s;
  port_power_source_config port_power_source_config_inst (.*);
  initial forever #5 mclk_i = ~mclk_i;
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= {24'h00_0000, d};
    @(posedge mclk_i);
    penable_i <= 1;
    n = 0;
    do begin @(posedge mclk_i); n++; end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) begin fail_count++; print_verdict; end
    r = prdata_o; e = pslverr_o; psel_i <= 0; penable_i <= 0;
    @(posedge mclk_i);
  endtask
  function logic [15:0] adr(input int q); adr = q ? 16'h3c08 : 16'h3c04; endfunction
  initial begin
    repeat (10) @(posedge mclk_i);
    srst_i <= 0;
    @(posedge mclk_i);
    for (p = 0; p < 2; p++) begin
      xfer(0, adr(p), 8'h00); `CHK(r, 32'h0000_0000)
      xfer(1, adr(p), 8'hff);
      xfer(0, adr(p), 8'h00); `CHK(r, 32'h0000_00bf)
      `CHK({shared_pins_o[p], perm_disable_o[p], fixed_attached_device_o[p]}, 3'b111)
    end
    $display("flag test done");
    for (p = 0; p < 2; p++) for (c = 0; c < 5; c++) begin
      xfer(1, adr(p), 8'(c));
      @(posedge mclk_i);
      `CHK({shared_pins_o[p], perm_disable_o[p], fixed_attached_device_o[p]}, 3'b000)
      for (s = 0; s < 8; s++) begin
        {gpio_power_i[p], ss_power_i[p], hs_power_i[p]} <= 3'(s);
        repeat (4) @(posedge mclk_i);
        x = c == 1 ? s[0] : c == 2 ? s[1] : c == 3 ? |s[1:0] : c == 4 ? s[2] : 1'b0;
        `CHK(port_power_en_o[p], x)
      end
    end
    $display("power test done");
    xfer(1, 16'h3c00, 8'hff); `CHK(e, 1'b1)
    xfer(0, 16'h3c00, 8'h00); `CHK(r, 32'h0000_0000)
    $display("address test done");
    print_verdict;
  end
endmodule // tb_port_power_source_config
